// *** src/sfrp_read_flags_top.sv ***
/*
  Read port and status flags of a nine-bit first-in first-out buffer.
  Assumes writer and reader share ref_clk_in and drive pins synchronously.
*/
// Notes on behaviour
// - Both read enables low take one word
// - Reads ignored while empty indicator low
// - Output enable low drives data bus
// - Empty indicator low exactly when nothing stored
// - Almost-empty low at count within offset, default seven
// - Almost-full low at space within offset, default seven
// - Full indicator low when full, writes ignored
// - Almost-full changes only on write clock
// - Reset clears pointers, sets flag levels
// - Reset samples second enable or load pin
// - Dual mode writes need first low, second high
// - Nine-bit data in, out and stored
`timescale 1ns/10ps
`default_nettype none
module sfrp_read_flags_top #(
  parameter int W = sfrp_pkg::DATA_W,
  parameter int DEPTH = sfrp_pkg::DEPTH
) (
  // Clock and resets
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic buffer_reset_n_in,
  // Write side
  input wire logic write_enable_a_n_in,
  input wire logic write_enable_b_or_offset_load_in,
  input wire logic [W-1:0] data_in,
  // Read side
  input wire logic read_enable_a_n_in,
  input wire logic read_enable_b_n_in,
  input wire logic output_enable_n_in,
  output logic [W-1:0] data_out,
  output logic data_oe_n_out,
  // Status flags
  output logic empty_indicator_n_out,
  output logic almost_empty_indicator_n_out,
  output logic almost_full_indicator_n_out,
  output logic full_indicator_n_out
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (W < AW || DEPTH <= sfrp_pkg::FULL_OFF_RST) begin : g_bad_size
      $error("sfrp_read_flags_top: data too narrow or depth too small");
    end
  endgenerate

  sfrp_fifo_if #(.W(W), .DEPTH(DEPTH)) fifo_bus ();

  wire clear_w = srst_in | ~buffer_reset_n_in;
  logic dual_mode_q;
  logic [AW-1:0] empty_off_q;
  logic [AW-1:0] full_off_q;
  sfrp_pkg::sfrp_load_e load_st_q;
  logic [W-1:0] data_q;

  // The store is written and read on the one clock, so its registered
  // count already stands in both domains without a further crossing
  sfrp_buffer #(.W(W), .DEPTH(DEPTH)) u_store (
    .clk_in(ref_clk_in),
    .clear_in(clear_w),
    .port(fifo_bus.store_mp)
  );

  wire [AW:0] level_w = fifo_bus.level;
  wire [AW:0] space_w = (AW+1)'(DEPTH) - level_w;
  wire rd_req_w = ~read_enable_a_n_in & ~read_enable_b_n_in;
  wire pop_w = rd_req_w & fifo_bus.rd_valid;
  wire wr_req_w = ~write_enable_a_n_in & write_enable_b_or_offset_load_in;
  wire load_wr_w = ~dual_mode_q & ~write_enable_b_or_offset_load_in &
    ~write_enable_a_n_in;
  wire [AW-1:0] load_val_w = data_in[sfrp_pkg::LOAD_FIELD_LSB +: AW];

  assign fifo_bus.wr_valid = wr_req_w;
  assign fifo_bus.wr_data = data_in;
  assign fifo_bus.rd_ready = rd_req_w;

  // Shared threshold test; a flag stays high while its amount is above the offset
  function automatic logic above_offset(input logic [AW:0] amount,
                                        input logic [AW-1:0] offset);
    return amount > {1'b0, offset};
  endfunction

  // Flags
  assign empty_indicator_n_out = fifo_bus.rd_valid;
  assign almost_empty_indicator_n_out = above_offset(level_w, empty_off_q);
  assign almost_full_indicator_n_out = above_offset(space_w, full_off_q);
  assign full_indicator_n_out = fifo_bus.wr_ready;
  assign data_out = data_q;
  // No tri-state here: the pad enable follows the pin, active low
  assign data_oe_n_out = output_enable_n_in;

  // Pin mode is caught on every clock of the reset, kept after release
  always_ff @(posedge ref_clk_in) begin
    if (clear_w) begin
      dual_mode_q <= write_enable_b_or_offset_load_in;
    end
  end

  // Offset loading alternates empty then full offset on each load write
  always_ff @(posedge ref_clk_in) begin
    if (clear_w) begin
      empty_off_q <= AW'(sfrp_pkg::EMPTY_OFF_RST);
      full_off_q <= AW'(sfrp_pkg::FULL_OFF_RST);
      load_st_q <= sfrp_pkg::SFRP_LOAD_EMPTY;
    end else if (load_wr_w) begin
      case (load_st_q)
        sfrp_pkg::SFRP_LOAD_EMPTY: begin
          empty_off_q <= load_val_w;
          load_st_q <= sfrp_pkg::SFRP_LOAD_FULL;
        end
        sfrp_pkg::SFRP_LOAD_FULL: begin
          full_off_q <= load_val_w;
          load_st_q <= sfrp_pkg::SFRP_LOAD_EMPTY;
        end
        default: begin
          load_st_q <= sfrp_pkg::SFRP_LOAD_EMPTY;
        end
      endcase
    end
  end

  // Output word holds until the next accepted read
  always_ff @(posedge ref_clk_in) begin
    if (clear_w) begin
      data_q <= '0;
    end else if (pop_w) begin
      data_q <= fifo_bus.rd_data;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (clear_w);

  a_read_takes_word: assert property (
    rd_req_w && empty_indicator_n_out |=> data_q == $past(fifo_bus.rd_data)
      && level_w == $past(level_w) - 1'b1 + (AW+1)'($past(wr_req_w && full_indicator_n_out)))
    else $error("read did not take a word");
  a_empty_blocks_read: assert property (
    rd_req_w && !empty_indicator_n_out |=> $stable(data_q))
    else $error("read accepted while empty");
  a_output_enable: assert property (
    $rose(output_enable_n_in) |-> data_oe_n_out ##1 data_oe_n_out == output_enable_n_in)
    else $error("bus drive does not follow output enable");
  a_empty_flag: assert property (
    empty_indicator_n_out == (level_w != '0))
    else $error("empty indicator wrong");
  a_almost_empty: assert property (
    !almost_empty_indicator_n_out |-> level_w <= {1'b0, empty_off_q})
    else $error("almost-empty indicator wrong");
  a_almost_full: assert property (
    almost_full_indicator_n_out == (level_w + {1'b0, full_off_q} < (AW+1)'(DEPTH)))
    else $error("almost-full indicator wrong");
  a_full_blocks_write: assert property (
    !full_indicator_n_out && !rd_req_w |=> !full_indicator_n_out && $stable(level_w))
    else $error("write accepted while full");
  a_reset_levels: assert property (@(posedge ref_clk_in) disable iff (1'b0)
    $fell(clear_w) |-> full_indicator_n_out && almost_full_indicator_n_out
      && !empty_indicator_n_out && !almost_empty_indicator_n_out
      && empty_off_q == AW'(sfrp_pkg::EMPTY_OFF_RST))
    else $error("reset flag levels wrong");
  a_mode_strap: assert property (@(posedge ref_clk_in) disable iff (1'b0)
    clear_w |=> dual_mode_q == $past(write_enable_b_or_offset_load_in))
    else $error("mode not caught at reset");
  a_dual_write: assert property (
    dual_mode_q && wr_req_w && full_indicator_n_out && !rd_req_w
      |=> level_w == $past(level_w) + 1'b1)
    else $error("dual-enable write not stored");

  // Load mode; a stray load must never move the stored count
  a_load_empty_off: assert property (
    load_wr_w && load_st_q == sfrp_pkg::SFRP_LOAD_EMPTY |=> empty_off_q == $past(load_val_w))
    else $error("empty offset not loaded");
  a_load_full_off: assert property (
    load_wr_w && load_st_q == sfrp_pkg::SFRP_LOAD_FULL |=> full_off_q == $past(load_val_w))
    else $error("full offset not loaded");
  a_load_alternates: assert property (
    load_wr_w |=> load_st_q != $past(load_st_q))
    else $error("offset load did not alternate");
  a_load_no_write: assert property (
    load_wr_w && !rd_req_w |=> $stable(level_w))
    else $error("offset load stored a word");

  // Flag levels against the registered count
  a_almost_empty_high: assert property (
    almost_empty_indicator_n_out |-> level_w > {1'b0, empty_off_q})
    else $error("almost-empty indicator high too early");
  a_almost_full_high: assert property (
    !almost_full_indicator_n_out |-> space_w <= {1'b0, full_off_q})
    else $error("almost-full indicator low too early");
  a_full_flag: assert property (
    full_indicator_n_out == (level_w != (AW+1)'(DEPTH)))
    else $error("full indicator wrong");
  a_flags_follow_state: assert property (
    !$stable(almost_full_indicator_n_out) |-> !$stable(level_w) || !$stable(full_off_q))
    else $error("almost-full moved without a registered cause");
  a_reset_pointers: assert property (@(posedge ref_clk_in) disable iff (1'b0)
    clear_w |=> level_w == '0 && data_q == '0)
    else $error("reset left words or data behind");

  // Data path; the output word must not drift between reads
  a_hold_no_read: assert property (
    !rd_req_w |=> $stable(data_q))
    else $error("output word changed without a read");
  a_write_data: assert property (
    wr_req_w && full_indicator_n_out && !empty_indicator_n_out
      |=> fifo_bus.rd_data == $past(data_in))
    else $error("stored word differs from written word");
  a_level_idle: assert property (
    !rd_req_w && !wr_req_w |=> $stable(level_w))
    else $error("count moved with no request");

  c_read_word: cover property (pop_w);
  c_read_write: cover property (pop_w && wr_req_w && full_indicator_n_out);
  c_reach_full: cover property (!full_indicator_n_out);
  c_offset_load: cover property (load_wr_w ##1 load_wr_w);
  c_dual_write: cover property (dual_mode_q && wr_req_w && full_indicator_n_out);
endmodule
`default_nettype wire

// *** src/sfrp_pkg.sv ***
/*
  Constants and types for the buffered read port with status flags.
  Assumes a single clock domain shared by the writing and reading logic.
*/
package sfrp_pkg;
  localparam int DATA_W = 9;
  localparam int DEPTH = 32;
  localparam int EMPTY_OFF_RST = 7;
  localparam int FULL_OFF_RST = 7;
  localparam int LOAD_FIELD_LSB = 0;
  typedef enum logic {SFRP_LOAD_EMPTY, SFRP_LOAD_FULL} sfrp_load_e;
endpackage

// *** src/sfrp_fifo_if.sv ***
/*
  Carrier between the flag logic and the word store.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface sfrp_fifo_if #(
  parameter int W = 9,
  parameter int DEPTH = 32
);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic [$clog2(DEPTH):0] level;
  modport store_mp (
    input wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data, level
  );
  modport user_mp (
    output wr_valid, wr_data, rd_ready,
    input wr_ready, rd_valid, rd_data, level
  );
endinterface
`default_nettype wire

// *** src/sfrp_buffer.sv ***
/*
  Word store: circular buffer with valid and ready on both sides.
  Assumes a synchronous active-high clear and a power-of-two depth.
*/
`timescale 1ns/10ps
`default_nettype none
module sfrp_buffer #(
  parameter int W = 9,
  parameter int DEPTH = 32
) (
  // Clock and clear
  input wire logic clk_in,
  input wire logic clear_in,
  // Store side of the carrier
  sfrp_fifo_if.store_mp port
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 8 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("sfrp_buffer: DEPTH must be a power of two, at least 8");
    end
  endgenerate

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] level_q;
  logic [AW:0] level_d;
  wire push = port.wr_valid & port.wr_ready;
  wire pop = port.rd_valid & port.rd_ready;

  // Full and empty come straight from the count, so they never lie
  assign port.wr_ready = level_q != (AW+1)'(DEPTH);
  assign port.rd_valid = level_q != '0;
  assign port.rd_data = mem_q[rptr_q];
  assign port.level = level_q;
  assign level_d = level_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk_in) begin
    if (clear_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
      level_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
      level_q <= level_d;
    end
  end

  // Storage has no reset; only the pointers and the count decide what is valid
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wptr_q] <= port.wr_data;
    end
  end

  a_level_bound: assert property (@(posedge clk_in) disable iff (clear_in)
    level_q <= (AW+1)'(DEPTH))
    else $error("buffer level above depth");
endmodule
`default_nettype wire

// *** test/sfrp_sys_model.sv ***
/*
  Model of the system logic that writes and reads the buffer pins.
  Assumes one caller; every request is set at a falling edge and held to the next one.
*/
`timescale 1ns/10ps
`default_nettype none
module sfrp_sys_model (
  // Clock
  input wire logic clk_in,
  // Pins toward the buffer
  output logic wr_a_n_out,
  output logic wr_b_out,
  output logic [8:0] data_out,
  output logic rd_a_n_out,
  output logic rd_b_n_out
);
  // Second enable idles high so the strap picks dual write mode at reset
  initial begin
    wr_a_n_out = 1'b1;
    wr_b_out = 1'b1;
    data_out = 9'h000;
    rd_a_n_out = 1'b1;
    rd_b_n_out = 1'b1;
  end
  // One edge of request; returns once that edge has landed
  task automatic cyc(input logic wa, input logic wb, input logic [8:0] d,
                     input logic ra, input logic rb);
    @(negedge clk_in);
    wr_a_n_out = wa;
    wr_b_out = wb;
    // Idle data line shows the inverse of its last value, so back-to-back idles toggle it
    data_out = wa ? ~data_out : d;
    rd_a_n_out = ra;
    rd_b_n_out = rb;
    @(posedge clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
/*
  Self-checking bench for the buffered read port and its flags.
  Assumes depth 32; dual write mode from the strap first, then load mode with new offsets.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic buffer_reset_n_in = 1'b1;
  logic oe_n = 1'b1;
  logic wa_n, wb, ra_n, rb_n, data_oe_n;
  logic [8:0] din, data_out;
  logic [3:0] flg;
  int fail_count = 0;
  int checked = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  sfrp_sys_model m_u (.clk_in(ref_clk_in), .wr_a_n_out(wa_n), .wr_b_out(wb),
    .data_out(din), .rd_a_n_out(ra_n), .rd_b_n_out(rb_n));
  sfrp_read_flags_top dut_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .buffer_reset_n_in(buffer_reset_n_in), .write_enable_a_n_in(wa_n),
    .write_enable_b_or_offset_load_in(wb), .data_in(din),
    .read_enable_a_n_in(ra_n), .read_enable_b_n_in(rb_n),
    .output_enable_n_in(oe_n), .data_out(data_out), .data_oe_n_out(data_oe_n),
    .empty_indicator_n_out(flg[3]), .almost_empty_indicator_n_out(flg[2]),
    .almost_full_indicator_n_out(flg[1]), .full_indicator_n_out(flg[0]));
  // Offsets the design should hold now; the load scenario moves them
  int eoff = sfrp_pkg::EMPTY_OFF_RST;
  int foff = sfrp_pkg::FULL_OFF_RST;
  // Flags expected for a stored count n
  function automatic logic [8:0] fexp(input int n);
    return {5'h00, n != 0, n > eoff, (sfrp_pkg::DEPTH - n) > foff, n != sfrp_pkg::DEPTH};
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatched %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk({5'h00, flg}, fexp(0));
    chk(data_out, 9'h000);
    @(negedge ref_clk_in);
    oe_n = 1'b0;
    #1;
    chk({8'h00, data_oe_n}, 9'h000);
    @(negedge ref_clk_in);
    oe_n = 1'b1;
    #1;
    chk({8'h00, data_oe_n}, 9'h001);
  endtask
  task automatic t_empty_read();
    m_u.cyc(1'b1, 1'b1, 9'h000, 1'b0, 1'b0);
    chk(data_out, 9'h000);
    chk({5'h00, flg}, fexp(0));
  endtask
  task automatic t_fill();
    m_u.cyc(1'b0, 1'b0, 9'h0aa, 1'b1, 1'b1);
    chk({5'h00, flg}, fexp(0));
    for (int i = 0; i < 33; i++) begin
      m_u.cyc(1'b0, 1'b1, 9'h150 + 9'(i), 1'b1, 1'b1);
      chk({5'h00, flg}, fexp(i < 32 ? i + 1 : 32));
    end
  endtask
  task automatic t_drain();
    m_u.cyc(1'b1, 1'b1, 9'h000, 1'b0, 1'b1);
    chk(data_out, 9'h000);
    chk({5'h00, flg}, fexp(32));
    for (int i = 0; i < 32; i++) begin
      m_u.cyc(1'b1, 1'b1, 9'h000, 1'b0, 1'b0);
      chk(data_out, 9'h150 + 9'(i));
      chk({5'h00, flg}, fexp(31 - i));
    end
    m_u.cyc(1'b1, 1'b1, 9'h000, 1'b0, 1'b0);
    chk(data_out, 9'h16f);
  endtask
  task automatic t_midrst();
    m_u.cyc(1'b0, 1'b1, 9'h1ff, 1'b1, 1'b1);
    m_u.cyc(1'b1, 1'b1, 9'h000, 1'b1, 1'b1);
    chk({5'h00, flg}, fexp(1));
    @(negedge ref_clk_in);
    buffer_reset_n_in = 1'b0;
    @(negedge ref_clk_in);
    buffer_reset_n_in = 1'b1;
    chk({5'h00, flg}, fexp(0));
    chk(data_out, 9'h000);
  endtask
  // Strap low at reset picks load mode; loads go empty, full, then empty again
  task automatic t_load();
    @(negedge ref_clk_in);
    srst_in = 1'b1;
    m_u.cyc(1'b1, 1'b0, 9'h000, 1'b1, 1'b1);
    @(negedge ref_clk_in);
    srst_in = 1'b0;
    m_u.cyc(1'b0, 1'b0, 9'h005, 1'b1, 1'b1);
    m_u.cyc(1'b0, 1'b0, 9'h004, 1'b1, 1'b1);
    m_u.cyc(1'b0, 1'b0, 9'h003, 1'b1, 1'b1);
    eoff = 3;
    foff = 4;
    chk({5'h00, flg}, fexp(0));
    for (int i = 0; i < 32; i++) begin
      m_u.cyc(1'b0, 1'b1, 9'h0c0 + 9'(i), 1'b1, 1'b1);
      chk({5'h00, flg}, fexp(i + 1));
    end
    m_u.cyc(1'b1, 1'b1, 9'h000, 1'b0, 1'b0);
    chk(data_out, 9'h0c0);
    chk({5'h00, flg}, fexp(31));
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_in);
    srst_in = 1'b0;
    t_reset();
    t_empty_read();
    t_fill();
    t_drain();
    t_midrst();
    t_load();
    close_out();
  end
endmodule
`default_nettype wire
